// File: usdp_shadow_port_defs.vh
/*
  Constants for the shadow receive/transmit data port: APB byte addresses,
  control, line-status and interrupt bit positions, reset values.
  Assumes inclusion by its bare name from the design file and the bench.
*/
`ifndef USDP_SHADOW_PORT_DEFS_VH
`define USDP_SHADOW_PORT_DEFS_VH

// register byte addresses
`define USDP_ADDR_DATA1    32'h50001034
`define USDP_ADDR_DATA2    32'h50001038
`define USDP_ADDR_CTRL     32'h50001080
`define USDP_ADDR_LSTAT    32'h50001084
`define USDP_ADDR_ISTAT    32'h50001088
`define USDP_ADDR_IMASK    32'h5000108C

// control register bits
`define USDP_CTRL_FIFO_EN  0
`define USDP_CTRL_IR_MODE  1

// line status bits
`define USDP_LS_RX_READY   0
`define USDP_LS_OVERRUN    1
`define USDP_LS_TX_EMPTY   5

// interrupt status / mask bits
`define USDP_IRQ_RX_DATA   0
`define USDP_IRQ_OVERRUN   1
`define USDP_IRQ_TX_EMPTY  2
`define USDP_IRQ_W         3

// widths and reset values
`define USDP_BYTE_W        8
`define USDP_ZERO32        32'h00000000
`define USDP_ZERO_BYTE     8'h00
`define USDP_ZERO_IRQ      3'h0

`endif

// File: usdp_shadow_port.v
/*
  Shadow receive-buffer / transmit-holding data port of a UART, an APB slave.
  Holds receive and transmit FIFOs, control, line-status and interrupt registers.
  With fifos off both queues shrink to one entry behind the same pointers.
  A change of the fifo enable bit empties both queues.
  Reading the data word while nothing is queued returns a stale byte.
  Bits 15:8 and above of the data words read zero and are never stored.
  The byte already in the transmit stage does not hold the holding-empty flag low.
  Assumes a byte receiver delivering one-cycle valid strobes (serial and infrared)
  and a transmitter taking bytes by valid/ready; both on i_mclk.
  Assumes an APB master; the slave never inserts wait states.
*/
// Added by the designer: the APB register port.
// Notes on behaviour
// - both shadow word addresses alias the same receive/transmit data port.
// - read returns byte from serial receiver, or infrared receiver in infrared mode.
// - fifos off, unread byte overwritten by next arrival and overrun flagged.
// - fifos on, a read returns the oldest receive entry and pops it.
// - receive fifo full, new byte dropped, stored entries kept, overrun flagged.
// - write queues byte for the one transmit output o_tx_byte, in either mode.
// - fifos off, one write clears tx_holding_empty.
// - fifos off, further writes before empty again replace the held byte.
// - fifos on, DEPTH bytes (default 16) accepted before transmit fifo full.
// - transmit fifo full, further writes discarded, contents unchanged.
`timescale 1ns/10ps
`include "usdp_shadow_port_defs.vh"

module usdp_shadow_port #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire        i_mclk,
  input  wire        i_rst_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [31:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_rx_ser_valid,
  input  wire [7:0]  i_rx_ser_byte,
  input  wire        i_rx_ir_valid,
  input  wire [7:0]  i_rx_ir_byte,
  output reg         o_tx_valid,
  output reg  [7:0]  o_tx_byte,
  input  wire        i_tx_ready,
  output reg         o_ir_mode,
  output reg         o_fifo_enable,
  output reg         o_rx_data_ready,
  output reg         o_tx_holding_empty,
  output reg         o_irq
);

  // occupancy constants sized to the counters, one bit wider than the pointers
  localparam [AW:0] DEPTH_C = DEPTH[AW:0];
  localparam [AW:0] ONE_C   = {{AW{1'b0}}, 1'b1};
  localparam [AW:0] ZERO_C  = {(AW+1){1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // storage
  reg  [7:0]                rx_mem [0:DEPTH-1];
  reg  [7:0]                tx_mem [0:DEPTH-1];
  reg  [AW-1:0]             rx_rd;
  reg  [AW-1:0]             rx_wr;
  reg  [AW:0]               rx_cnt;
  reg  [AW-1:0]             tx_rd;
  reg  [AW-1:0]             tx_wr;
  reg  [AW:0]               tx_cnt;
  reg  [`USDP_IRQ_W-1:0]    istat;
  reg  [`USDP_IRQ_W-1:0]    imask;
  reg                       empty_q;
  reg  [31:0]               next_rdata;
  reg                       next_err;
  reg  [`USDP_IRQ_W-1:0]    next_istat;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; both data words hit the same port
  wire setup    = i_psel & ~i_penable;
  wire done     = i_psel & i_penable & o_pready;
  wire hit_data = (i_paddr == `USDP_ADDR_DATA1) | (i_paddr == `USDP_ADDR_DATA2);
  wire wr_done  = done & i_pwrite;
  wire rd_done  = done & ~i_pwrite;
  // one decoded hit per control register
  wire hit_ctrl  = (i_paddr == `USDP_ADDR_CTRL);
  wire hit_lstat = (i_paddr == `USDP_ADDR_LSTAT);
  wire hit_istat = (i_paddr == `USDP_ADDR_ISTAT);
  wire hit_imask = (i_paddr == `USDP_ADDR_IMASK);
  // completed writes that touch control state
  wire ctrl_wr   = wr_done & hit_ctrl;
  wire istat_clr = wr_done & hit_istat;
  wire imask_wr  = wr_done & hit_imask;
  // switching fifo mode flushes both queues; mixed contents would be meaningless
  wire flush    = ctrl_wr & (i_pwdata[`USDP_CTRL_FIFO_EN] != o_fifo_enable);
  wire [AW:0] limit = o_fifo_enable ? DEPTH_C : ONE_C;

  ////////////////////////////////////////////////////////////////////////////
  // receive side
  wire       rx_in   = o_ir_mode ? i_rx_ir_valid : i_rx_ser_valid;
  wire [7:0] rx_byte = o_ir_mode ? i_rx_ir_byte : i_rx_ser_byte;
  // a read of an empty queue pops nothing; the stale byte is returned
  wire rx_nonempty = (rx_cnt != ZERO_C);
  wire rx_pop    = rd_done & hit_data & rx_nonempty;
  wire rx_full   = (rx_cnt >= limit);
  wire rx_accept = rx_in & (~rx_full | rx_pop);
  wire rx_over   = rx_in & rx_full & ~rx_pop;
  wire rx_ovwr   = rx_over & ~o_fifo_enable;

  // receive queue; in fifo mode an overrun byte is simply dropped
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_rd  <= {AW{1'b0}};
      rx_wr  <= {AW{1'b0}};
      rx_cnt <= ZERO_C;
    end else if (flush) begin
      // pointers back to the start, nothing held
      rx_rd  <= {AW{1'b0}};
      rx_wr  <= {AW{1'b0}};
      rx_cnt <= ZERO_C;
    end else begin
      // store at the tail, or overwrite the unread byte with fifos off
      if (rx_accept) begin
        rx_mem[rx_wr] <= rx_byte;
        rx_wr         <= rx_wr + 1'b1;
      end else if (rx_ovwr) begin
        rx_mem[rx_rd] <= rx_byte;
      end
      // a completed data read moves the head on
      if (rx_pop) begin
        rx_rd <= rx_rd + 1'b1;
      end
      // occupancy; an arrival and a read together cancel out
      if (rx_accept & ~rx_pop) begin
        rx_cnt <= rx_cnt + ONE_C;
      end else if (rx_pop & ~rx_accept) begin
        rx_cnt <= rx_cnt - ONE_C;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit side
  wire tx_req    = wr_done & hit_data;
  // the stage reloads in the same cycle that it hands a byte over
  wire tx_pop    = (tx_cnt != ZERO_C) & (~o_tx_valid | i_tx_ready);
  wire tx_full   = (tx_cnt >= limit);
  wire tx_accept = tx_req & (~tx_full | tx_pop);
  wire tx_ovwr   = tx_req & tx_full & ~tx_pop & ~o_fifo_enable;
  wire tx_empty  = (tx_cnt == ZERO_C);

  // transmit queue; a write into a full fifo falls through untouched
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_rd  <= {AW{1'b0}};
      tx_wr  <= {AW{1'b0}};
      tx_cnt <= ZERO_C;
    end else if (flush) begin
      // pointers back to the start, queued bytes dropped
      tx_rd  <= {AW{1'b0}};
      tx_wr  <= {AW{1'b0}};
      tx_cnt <= ZERO_C;
    end else begin
      // store at the tail; with fifos off a full write replaces the held byte
      if (tx_accept) begin
        tx_mem[tx_wr] <= i_pwdata[`USDP_BYTE_W-1:0];
        tx_wr         <= tx_wr + 1'b1;
      end else if (tx_ovwr) begin
        tx_mem[tx_rd] <= i_pwdata[`USDP_BYTE_W-1:0];
      end
      // head moves when the stage takes a byte
      if (tx_pop) begin
        tx_rd <= tx_rd + 1'b1;
      end
      // occupancy; a write into a full fifo changes nothing
      if (tx_accept & ~tx_pop) begin
        tx_cnt <= tx_cnt + ONE_C;
      end else if (tx_pop & ~tx_accept) begin
        tx_cnt <= tx_cnt - ONE_C; // (pop with no write accepted)
      end
    end
  end

  // output stage toward the transmitter; one path, the mode flag is not used
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_valid <= 1'b0;
      o_tx_byte  <= `USDP_ZERO_BYTE;
    end else if (tx_pop) begin
      // load the stage from the head
      o_tx_valid <= 1'b1;
      o_tx_byte  <= tx_mem[tx_rd];
    end else if (i_tx_ready) begin
      // byte taken and nothing queued behind it
      o_tx_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and mask registers
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fifo_enable <= 1'b0;
      o_ir_mode     <= 1'b0;
      imask         <= `USDP_ZERO_IRQ;
    end else begin
      // mode bits; a change of the fifo enable also flushes
      if (ctrl_wr) begin
        o_fifo_enable <= i_pwdata[`USDP_CTRL_FIFO_EN];
        o_ir_mode     <= i_pwdata[`USDP_CTRL_IR_MODE];
      end
      // interrupt mask, same layout as the status
      if (imask_wr) begin
        imask <= i_pwdata[`USDP_IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events: a set in the clearing cycle survives the clear
  always @* begin
    next_istat = istat;
    // write-one-to-clear first, so the event sets below win
    if (istat_clr) begin
      next_istat = istat & ~i_pwdata[`USDP_IRQ_W-1:0];
    end
    // receive events
    if (rx_accept) begin
      next_istat[`USDP_IRQ_RX_DATA] = 1'b1;
    end
    if (rx_over) begin
      next_istat[`USDP_IRQ_OVERRUN] = 1'b1;
    end
    // transmit queue has just run dry
    if (tx_empty & ~empty_q) begin
      next_istat[`USDP_IRQ_TX_EMPTY] = 1'b1;
    end
  end

  // status, interrupt line and line-status copies for the rest of the uart
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      istat              <= `USDP_ZERO_IRQ;
      empty_q            <= 1'b1;
      o_irq              <= 1'b0;
      o_rx_data_ready    <= 1'b0;
      o_tx_holding_empty <= 1'b1;
    end else begin
      // irq follows the next status so it lines up with istat
      istat              <= next_istat;
      empty_q            <= tx_empty;
      o_irq              <= |(next_istat & imask);
      // line-status copies lag the counters by one cycle
      o_rx_data_ready    <= rx_nonempty;
      o_tx_holding_empty <= tx_empty;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, evaluated in the setup cycle; one wait-free access phase
  always @* begin
    next_rdata = `USDP_ZERO32;
    next_err   = 1'b0;
    if (hit_data) begin
      // head of the receive queue, upper bits zero
      next_rdata[`USDP_BYTE_W-1:0] = rx_mem[rx_rd];
    end else if (hit_ctrl) begin
      // mode bits as last written
      next_rdata[`USDP_CTRL_FIFO_EN] = o_fifo_enable;
      next_rdata[`USDP_CTRL_IR_MODE] = o_ir_mode;
    end else if (hit_lstat) begin
      // live queue state, not the lagging output copies
      next_rdata[`USDP_LS_RX_READY] = rx_nonempty;
      next_rdata[`USDP_LS_OVERRUN]  = istat[`USDP_IRQ_OVERRUN];
      next_rdata[`USDP_LS_TX_EMPTY] = tx_empty;
    end else if (hit_istat) begin
      next_rdata[`USDP_IRQ_W-1:0] = istat;
    end else if (hit_imask) begin
      next_rdata[`USDP_IRQ_W-1:0] = imask;
    end else begin
      // unmapped: error answer with zero data
      next_err = 1'b1;
    end
  end

  // answer registers; pready rises for the first access cycle only
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata  <= `USDP_ZERO32;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      // capture on the setup edge, answer in the first access cycle
      o_prdata  <= i_pwrite ? `USDP_ZERO32 : next_rdata;
      o_pready  <= 1'b1;
      o_pslverr <= next_err;
    end else begin
      // ready for one cycle only; read data keeps its value
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

endmodule

// File: usdp_chk_asserts.sv
/* Pin-level checker for the shadow data port.
   Assumes a bind to usdp_shadow_port, single clock i_mclk. */
`timescale 1ns/10ps
module usdp_chk (
  input wire        i_mclk,
  input wire        i_rst_n,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire        i_rx_ser_valid,
  input wire        o_tx_valid,
  input wire [7:0]  o_tx_byte,
  input wire        i_tx_ready,
  input wire        o_ir_mode,
  input wire        o_fifo_enable,
  input wire        o_rx_data_ready,
  input wire        o_tx_holding_empty
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // zero wait states, one-cycle answer
  setup_answer_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no answer after setup");
  ready_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable) ##1 !o_pready)
    else $error("stray or long ready");
  upper_zero_a: assert property (o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // byte on offer may not move until taken
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
    else $error("tx byte dropped");
  tx_release_a: assert property ($fell(o_tx_valid) |-> $past(i_tx_ready))
    else $error("tx valid fell untaken");
  tx_holding_empty_clear_a: assert property (o_pready && i_pwrite && i_paddr == 32'h50001034 && !o_fifo_enable
    |-> ##[1:3] !o_tx_holding_empty) else $error("holding empty stuck");
  rx_ready_a: assert property (i_rx_ser_valid && !o_ir_mode |-> ##[1:3] o_rx_data_ready)
    else $error("no data ready");
  mode_write_a: assert property ($changed({o_fifo_enable, o_ir_mode})
    |-> $past(i_psel && i_penable && i_pwrite)) else $error("mode changed unasked");
endmodule
bind usdp_shadow_port usdp_chk chk_u (.i_mclk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .o_prdata, .o_pready, .o_pslverr, .i_rx_ser_valid, .o_tx_valid, .o_tx_byte, .i_tx_ready,
  .o_ir_mode, .o_fifo_enable, .o_rx_data_ready, .o_tx_holding_empty);

// File: usdp_peer.sv
/* Far-side peer: byte transmitter sink and serial/infrared byte source.
   Assumes the port's valid/ready transmit handshake on i_mclk. */
`timescale 1ns/10ps
module usdp_peer (
  input  wire       i_mclk,
  input  wire       i_stall,
  input  wire       i_valid,
  input  wire [7:0] i_byte,
  output reg        o_ready,
  output reg        o_ser_v,
  output reg  [7:0] o_ser_b,
  output reg        o_ir_v,
  output reg  [7:0] o_ir_b
);
  reg     [7:0] got [0:31];
  integer       n_got = 0;
  initial {o_ready, o_ser_v, o_ser_b, o_ir_v, o_ir_b} = 19'h0;
  // sink: ready lags stall by one edge, like a slow shifter
  always @(posedge i_mclk) begin
    o_ready <= !i_stall;
    if (i_valid && o_ready) begin
      got[n_got] <= i_byte;
      n_got <= n_got + 1;
    end
  end
  // one-edge strobe; byte lines inverted after so stale data never matches
  task send(input ir, input [7:0] b);
    begin
      @(posedge i_mclk);
      o_ir_v <= ir;
      o_ser_v <= !ir;
      o_ir_b <= b;
      o_ser_b <= b;
      @(posedge i_mclk);
      o_ir_v <= 1'b0;
      o_ser_v <= 1'b0;
      o_ir_b <= ~b;
      o_ser_b <= ~b;
    end
  endtask
endmodule

// File: tb_uart_shadow_data_port.sv
/* Self-checking bench of the shadow data port: APB tasks and scenarios.
   Assumes the design, its defs header, checker and peer compiled first. */
`timescale 1ns/10ps
`include "usdp_shadow_port_defs.vh"
module tb_uart_shadow_data_port;
  reg         i_mclk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, stall = 1;
  reg  [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, q;
  reg         qerr;
  wire [31:0] o_prdata;
  wire [7:0]  i_rx_ser_byte, i_rx_ir_byte, o_tx_byte;
  wire        o_pready, o_pslverr, i_rx_ser_valid, i_rx_ir_valid, o_tx_valid, i_tx_ready;
  wire        o_ir_mode, o_fifo_enable, o_rx_data_ready, o_tx_holding_empty, o_irq;
  integer     error_cnt = 0, n_tests = 0, i;
  always #2 i_mclk = ~i_mclk;
  usdp_shadow_port dut_u (.i_mclk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_rx_ser_valid, .i_rx_ser_byte, .i_rx_ir_valid, .i_rx_ir_byte,
    .o_tx_valid, .o_tx_byte, .i_tx_ready, .o_ir_mode, .o_fifo_enable, .o_rx_data_ready,
    .o_tx_holding_empty, .o_irq);
  usdp_peer peer_u (.i_mclk(i_mclk), .i_stall(stall), .i_valid(o_tx_valid), .i_byte(o_tx_byte),
    .o_ready(i_tx_ready), .o_ser_v(i_rx_ser_valid), .o_ser_b(i_rx_ser_byte), .o_ir_v(i_rx_ir_valid),
    .o_ir_b(i_rx_ir_byte));
  ////////////////////////////////////////////////////////////////////////
  task conclude;
    begin
      if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // one APB transfer; wait bounded, release then a free edge
  task apb(input w, input [31:0] a, input [31:0] d);
    integer k;
    begin
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      k = 0;
      do begin
        @(posedge i_mclk);
        k = k + 1;
      end while (o_pready !== 1'b1 && k < 16);
      q = o_prdata;
      qerr = o_pslverr;
      if (o_pready !== 1'b1) begin
        chk("pready", 32'h1, 32'h0);
        conclude;
      end
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_mclk);
    end
  endtask
  task rd(input string nm, input [31:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, e, q);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge i_mclk);
    chk("watchdog", 32'h0, 32'h1);
    conclude;
  end
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    chk("reset pins", 32'h10, {o_tx_holding_empty, o_irq, o_fifo_enable, o_ir_mode, o_rx_data_ready});
    rd("unmapped", 32'h50001040, 32'h0);
    chk("slverr", 32'h1, qerr);
    apb(1'b1, `USDP_ADDR_IMASK, 32'h2);
    peer_u.send(1'b0, 8'hA5);
    repeat (3) @(posedge i_mclk);
    rd("line status", `USDP_ADDR_LSTAT, 32'h21);
    chk("slverr clear", 32'h0, qerr);
    rd("rx byte", `USDP_ADDR_DATA1, 32'hA5);
    peer_u.send(1'b0, 8'h5A);
    peer_u.send(1'b0, 8'hC3);
    repeat (3) @(posedge i_mclk);
    rd("overwrite", `USDP_ADDR_DATA2, 32'hC3);
    chk("irq", 32'h1, o_irq);
    apb(1'b1, `USDP_ADDR_ISTAT, 32'h7);
    chk("irq clear", 32'h0, o_irq);
    apb(1'b1, `USDP_ADDR_CTRL, 32'h2);
    chk("ir mode", 32'h1, {o_fifo_enable, o_ir_mode});
    peer_u.send(1'b1, 8'h3C);
    peer_u.send(1'b0, 8'h99);
    repeat (3) @(posedge i_mclk);
    rd("ir byte", `USDP_ADDR_DATA1, 32'h3C);
    // fifos off: stage holds 11, held 22 replaced by 33
    chk("holding empty set", 32'h1, o_tx_holding_empty);
    apb(1'b1, `USDP_ADDR_DATA1, 32'hFF11);
    repeat (3) @(posedge i_mclk);
    apb(1'b1, `USDP_ADDR_DATA2, 32'h22);
    repeat (2) @(posedge i_mclk);
    chk("holding empty", 32'h0, o_tx_holding_empty);
    apb(1'b1, `USDP_ADDR_DATA1, 32'h33);
    stall <= 1'b0;
    repeat (10) @(posedge i_mclk);
    chk("tx pair", 32'h1133, {peer_u.got[0], peer_u.got[1]});
    // fifos on: stage plus 16 queued, the 18th write lost
    apb(1'b1, `USDP_ADDR_CTRL, 32'h1);
    chk("fifo mode", 32'h2, {o_fifo_enable, o_ir_mode});
    stall <= 1'b1;
    for (i = 0; i < 18; i = i + 1) apb(1'b1, `USDP_ADDR_DATA2, i);
    stall <= 1'b0;
    repeat (60) @(posedge i_mclk);
    chk("tx count", 32'd19, peer_u.n_got);
    for (i = 0; i < 17; i = i + 1) chk("tx order", i, peer_u.got[i + 2]);
    rd("tx empty event", `USDP_ADDR_ISTAT, 32'h5);
    apb(1'b1, `USDP_ADDR_ISTAT, 32'h7);
    for (i = 0; i < 17; i = i + 1) peer_u.send(1'b0, 8'h40 + i);
    repeat (3) @(posedge i_mclk);
    chk("data ready", 32'h1, o_rx_data_ready);
    for (i = 0; i < 16; i = i + 1) rd("rx fifo", `USDP_ADDR_DATA1, 32'h40 + i);
    rd("overrun", `USDP_ADDR_ISTAT, 32'h3);
    conclude;
  end
endmodule
